// ==== pkg/rx_frame_pkg.sv ====
// Shared constants and carrier types for the receive packet framer
package rx_frame_pkg;

    localparam int DATA_W      = 128;
    localparam int DWORD_W     = 32;
    localparam int LANE_W      = 2;
    localparam int USER_W      = 22;
    localparam int MARK_W      = 5;

    // Sideband field positions
    localparam int START_LO    = 10;
    localparam int START_HI    = 14;
    localparam int END_LO      = 17;
    localparam int END_HI      = 21;

    // Marker encodings
    localparam logic [MARK_W-1:0] MARK_NONE     = 5'h00;
    localparam logic              MARK_PRESENT  = 1'b1;
    localparam logic [1:0]        START_LOW_POS = 2'h0;
    localparam logic [1:0]        END_LOW_POS   = 2'h3;

    // Lane numbers
    localparam logic [LANE_W-1:0] LANE_FIRST    = 2'h0;
    localparam logic [LANE_W-1:0] LANE_UPPER    = 2'h2;
    localparam logic [LANE_W-1:0] LANE_LAST     = 2'h3;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [MARK_W-1:0] start_mark;
        logic [MARK_W-1:0] end_mark;
    } beat_type;

    localparam beat_type BEAT_RESET = '0;

    typedef enum logic [1:0] {
        FILL_IDLE = 2'b00,
        FILL_PKT  = 2'b01,
        FILL_TAIL = 2'b11
    } fill_state_type;

endpackage

// ==== src/rx_beat_holder.sv ====
// Output register stage holding one stream beat toward the sink
`timescale 1ns/100ps
module rx_beat_holder
    import rx_frame_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    input  wire logic              load_i,
    input  wire beat_type          beat_i,
    output      logic              can_load_o,
    input  wire logic              rx_ready_i,
    output      logic              rx_valid_o,
    output      logic [DATA_W-1:0] rx_data_o,
    output      logic [USER_W-1:0] rx_user_o
);

    typedef struct packed {
        logic     valid;
        beat_type beat;
    } hold_state_type;

    hold_state_type s_q;
    hold_state_type s_d;

    // A beat leaves only on valid and ready together
    assign can_load_o = !s_q.valid || rx_ready_i;

    always_comb begin
        s_d = s_q;
        if (can_load_o) begin
            s_d.valid = load_i;
            s_d.beat  = load_i ? beat_i : BEAT_RESET;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_valid_o = s_q.valid;
    assign rx_data_o  = s_q.beat.data;
    assign rx_user_o  = {s_q.beat.end_mark, 2'h0, s_q.beat.start_mark, 10'h000};

    property p_hold_stable;
        @(posedge ref_clk_i) disable iff (srst_i)
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o) && $stable(rx_user_o);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("beat changed while stalled");

    property p_start_code;
        @(posedge ref_clk_i) disable iff (srst_i)
        rx_valid_o && rx_user_o[START_HI] |-> rx_user_o[12:10] == 3'h0;
    endproperty
    a_start_code: assert property (p_start_code) else $error("bad start position");

    property p_end_code;
        @(posedge ref_clk_i) disable iff (srst_i)
        rx_valid_o && rx_user_o[END_HI] |-> rx_user_o[18:17] == 2'h3;
    endproperty
    a_end_code: assert property (p_end_code) else $error("bad end position");

    property p_straddle;
        @(posedge ref_clk_i) disable iff (srst_i)
        rx_valid_o && rx_user_o[START_HI] && rx_user_o[END_HI] && rx_user_o[13]
        |-> !rx_user_o[20];
    endproperty
    a_straddle: assert property (p_straddle) else $error("straddle end not in lower half");

    property p_single;
        @(posedge ref_clk_i) disable iff (srst_i)
        rx_valid_o && rx_user_o[START_HI] && rx_user_o[END_HI] && !rx_user_o[13]
        |-> rx_user_o[20];
    endproperty
    a_single: assert property (p_single) else $error("single beat packet too short");

    property p_drop_valid;
        @(posedge ref_clk_i) disable iff (srst_i)
        rx_valid_o && rx_ready_i && !load_i |=> !rx_valid_o;
    endproperty
    a_drop_valid: assert property (p_drop_valid) else $error("valid held with nothing to send");

endmodule

// ==== src/rx_stream_framer.sv ====
// Receive packet framer: packs dwords into 128-bit beats with start and end markers
`timescale 1ns/100ps
module rx_stream_framer
    import rx_frame_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               srst_i,
    input  wire logic               pkt_valid_i,
    input  wire logic [DWORD_W-1:0] pkt_dword_i,
    input  wire logic               pkt_last_i,
    output      logic               pkt_ready_o,
    input  wire logic               rx_ready_i,
    output      logic               rx_valid_o,
    output      logic [DATA_W-1:0]  rx_data_o,
    output      logic [USER_W-1:0]  rx_user_o
);

    typedef struct packed {
        fill_state_type    state;
        logic [LANE_W-1:0] lane;
        logic              done;
        beat_type          beat;
    } fill_reg_type;

    fill_reg_type s_q;
    fill_reg_type s_d;
    logic         can_load;
    logic         move;
    logic         fire;

    function automatic logic [MARK_W-1:0] mark_code(input logic [LANE_W-1:0] lane, input logic [1:0] low);
        mark_code = {MARK_PRESENT, lane, low};
    endfunction

    // Beats are only assembled, never queued: one beat in work plus one in the holder
    assign move        = s_q.done && can_load;
    assign fire        = pkt_valid_i && !s_q.done;
    assign pkt_ready_o = !s_q.done;

    always_comb begin
        logic [LANE_W-1:0] lane_v;
        logic              first_v;
        logic              had_start_v;
        lane_v      = s_q.lane;
        first_v     = (s_q.state != FILL_PKT);
        had_start_v = s_q.beat.start_mark[MARK_W-1];
        s_d         = s_q;
        if (move) begin
            s_d.beat = BEAT_RESET;
            s_d.lane = LANE_FIRST;
            s_d.done = 1'b0;
            if (s_q.state == FILL_TAIL) begin
                s_d.state = FILL_IDLE;
            end
        end else if (fire) begin
            // Starts only on an even dword pair boundary
            if (first_v && lane_v[0]) begin
                lane_v = LANE_UPPER;
            end
            s_d.beat.data[DWORD_W*lane_v +: DWORD_W] = pkt_dword_i;
            if (first_v) begin
                s_d.beat.start_mark = mark_code(lane_v, START_LOW_POS);
            end
            if (pkt_last_i) begin
                s_d.beat.end_mark = mark_code(lane_v, END_LOW_POS);
            end
            s_d.lane = lane_v + 2'h1;
            // Close on full beat, end in upper half, or a second start would be needed
            s_d.done = (lane_v == LANE_LAST) || (pkt_last_i && lane_v[1])
                     || (pkt_last_i && (first_v || had_start_v));
            if (pkt_last_i) begin
                s_d.state = lane_v[1] ? FILL_IDLE : FILL_TAIL;
            end else begin
                s_d.state = FILL_PKT;
            end
        end else if (s_q.state == FILL_TAIL && !s_q.done) begin
            // No straddle partner waiting: send the ending beat now
            s_d.done = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    rx_beat_holder u_holder (
        .ref_clk_i  (ref_clk_i),
        .srst_i     (srst_i),
        .load_i     (move),
        .beat_i     (s_q.beat),
        .can_load_o (can_load),
        .rx_ready_i (rx_ready_i),
        .rx_valid_o (rx_valid_o),
        .rx_data_o  (rx_data_o),
        .rx_user_o  (rx_user_o)
    );

    property p_end_mark;
        @(posedge ref_clk_i) disable iff (srst_i)
        fire && pkt_last_i |=> s_q.beat.end_mark[MARK_W-1] && s_q.beat.end_mark[1:0] == END_LOW_POS;
    endproperty
    a_end_mark: assert property (p_end_mark) else $error("last dword not marked as end");

    property p_one_start;
        @(posedge ref_clk_i) disable iff (srst_i)
        fire && s_q.state != FILL_PKT |-> !s_q.beat.start_mark[MARK_W-1];
    endproperty
    a_one_start: assert property (p_one_start) else $error("second start in one beat");

    property p_tail_flush;
        @(posedge ref_clk_i) disable iff (srst_i)
        s_q.state == FILL_TAIL && !s_q.done && !pkt_valid_i |=> s_q.done;
    endproperty
    a_tail_flush: assert property (p_tail_flush) else $error("ending beat not released");

    property p_first_start;
        @(posedge ref_clk_i) disable iff (srst_i)
        fire && s_q.state != FILL_PKT |=> s_q.beat.start_mark[MARK_W-1];
    endproperty
    a_first_start: assert property (p_first_start) else $error("first dword without start flag");

    property p_mid_no_start;
        @(posedge ref_clk_i) disable iff (srst_i)
        fire && s_q.state == FILL_PKT |=> $stable(s_q.beat.start_mark);
    endproperty
    a_mid_no_start: assert property (p_mid_no_start) else $error("start field changed mid packet");

    property p_upper_start;
        @(posedge ref_clk_i) disable iff (srst_i)
        fire && s_q.state == FILL_TAIL |=> s_q.beat.start_mark == {MARK_PRESENT, LANE_UPPER, START_LOW_POS};
    endproperty
    a_upper_start: assert property (p_upper_start) else $error("straddled start not in upper half");

    property p_full_close;
        @(posedge ref_clk_i) disable iff (srst_i)
        fire && s_q.lane == LANE_LAST |=> s_q.done;
    endproperty
    a_full_close: assert property (p_full_close) else $error("full beat not closed");

    property p_upper_end;
        @(posedge ref_clk_i) disable iff (srst_i)
        fire && pkt_last_i && s_q.state == FILL_PKT && s_q.lane[1] |=> s_q.done;
    endproperty
    a_upper_end: assert property (p_upper_end) else $error("upper half end not closed");

    // Holder stalled: the work beat must not move or change
    property p_stall_keep;
        @(posedge ref_clk_i) disable iff (srst_i)
        s_q.done && !can_load |=> s_q.done && $stable(s_q.beat);
    endproperty
    a_stall_keep: assert property (p_stall_keep) else $error("closed beat changed while stalled");

    property p_move_valid;
        @(posedge ref_clk_i) disable iff (srst_i)
        move |=> rx_valid_o && rx_data_o == $past(s_q.beat.data);
    endproperty
    a_move_valid: assert property (p_move_valid) else $error("moved beat not presented");

    property p_move_clear;
        @(posedge ref_clk_i) disable iff (srst_i)
        move |=> !s_q.done && s_q.lane == LANE_FIRST;
    endproperty
    a_move_clear: assert property (p_move_clear) else $error("work beat not reopened");

endmodule

// ==== tb/rx_sink_model.sv ====
// Sink model that takes receive beats, stalling on request
`timescale 1ns/100ps
module rx_sink_model (
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    input  wire logic stall_en_i,
    input  wire logic stall_bit_i,
    input  wire logic rx_valid_i,
    output      logic rx_ready_o
);
    initial rx_ready_o = 1'b0;
    // Data and markers are never looked at here, valid or not
    always @(posedge ref_clk_i) begin
        rx_ready_o <= #1 !srst_i && (!stall_en_i || stall_bit_i);
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the receive framer
`timescale 1ns/100ps
module tb;
    import rx_frame_pkg::*;
    logic               ref_clk_i = 1'b0;
    logic               srst_i = 1'b1;
    logic               pkt_valid_i = 1'b0;
    logic [DWORD_W-1:0] pkt_dword_i = '0;
    logic               pkt_last_i = 1'b0;
    logic               pkt_ready_o, rx_ready_i, rx_valid_o;
    logic [DATA_W-1:0]  rx_data_o;
    logic [USER_W-1:0]  rx_user_o;
    logic               stall_en = 1'b0, stall_bit = 1'b0, first = 1'b0, pend = 1'b0, held = 1'b0;
    logic [31:0]        rnd = 32'hA311;
    logic [31:0]        stall_rnd = 32'hA311;
    int                 seq [5] = '{5, 6, 6, 3, 4};
    int                 mismatches = 0, checks = 0, lane = 0;
    beat_type           work = BEAT_RESET, hold_b, e;
    beat_type           expq[$];

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [DATA_W-1:0] user_of(beat_type b);
        return DATA_W'({b.end_mark, 2'h0, b.start_mark, 10'h000});
    endfunction
    task automatic check(logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic send_pkt(int n, int gap);
        int k;
        for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            pkt_valid_i = 1'b1;
            pkt_dword_i = rnd;
            pkt_last_i = (i == n - 1);
            first = (i == 0);
            k = 0;
            do begin
                @(posedge ref_clk_i);
                k++;
            end while (!pkt_ready_o && k < 50);
            if (k >= 50) begin
                check('0, DATA_W'(1));
                final_report();
            end
            #1;
        end
        pkt_valid_i = 1'b0;
        repeat (gap) @(posedge ref_clk_i);
        #1;
    endtask

    // Packing model follows taken dwords; straddle only if next start is immediate
    always @(posedge ref_clk_i) begin
        if (pend && !(pkt_valid_i && pkt_ready_o && first)) begin
            expq.push_back(work);
            work = BEAT_RESET;
            lane = 0;
            pend = 1'b0;
        end
        if (pkt_valid_i && pkt_ready_o) begin
            work.data[lane*32 +: 32] = pkt_dword_i;
            if (first) work.start_mark = {1'b1, 2'(lane), 2'h0};
            if (pkt_last_i) work.end_mark = {1'b1, 2'(lane), 2'h3};
            pend = pkt_last_i && lane < 2;
            if (pend) lane = 2;
            else if (pkt_last_i || lane == 3) begin
                expq.push_back(work);
                work = BEAT_RESET;
                lane = 0;
            end else lane++;
        end
        if (held) begin
            check(rx_data_o, hold_b.data);
            check(DATA_W'(rx_user_o), user_of(hold_b));
        end
        held = rx_valid_o && !rx_ready_i;
        hold_b = '{rx_data_o, rx_user_o[START_HI:START_LO], rx_user_o[END_HI:END_LO]};
        if (rx_valid_o && rx_ready_i) begin
            if (expq.size() == 0) check(DATA_W'(1), '0);
            else begin
                e = expq.pop_front();
                check(rx_data_o, e.data);
                check(DATA_W'(rx_user_o), user_of(e));
            end
        end
    end

    always #2 ref_clk_i = ~ref_clk_i;

    // Fresh stall draw every cycle, so a stalled sink always frees up
    always @(posedge ref_clk_i) begin
        #1;
        stall_rnd = lfsr(stall_rnd);
        stall_bit = stall_rnd[5];
    end

    rx_sink_model i_sink (
        .ref_clk_i  (ref_clk_i),
        .srst_i     (srst_i),
        .stall_en_i (stall_en),
        .stall_bit_i(stall_bit),
        .rx_valid_i (rx_valid_o),
        .rx_ready_o (rx_ready_i)
    );
    rx_stream_framer i_dut (
        .ref_clk_i  (ref_clk_i),
        .srst_i     (srst_i),
        .pkt_valid_i(pkt_valid_i),
        .pkt_dword_i(pkt_dword_i),
        .pkt_last_i (pkt_last_i),
        .pkt_ready_o(pkt_ready_o),
        .rx_ready_i (rx_ready_i),
        .rx_valid_o (rx_valid_o),
        .rx_data_o  (rx_data_o),
        .rx_user_o  (rx_user_o)
    );

    initial begin
        repeat (20) @(posedge ref_clk_i);
        #1 srst_i = 1'b0;
        @(posedge ref_clk_i);
        #1 check(DATA_W'({pkt_ready_o, rx_valid_o}), DATA_W'(2'b10));
        // Every end lane with a gap, then straddles back to back
        for (int n = 3; n <= 8; n++) send_pkt(n, 2);
        foreach (seq[i]) send_pkt(seq[i], 0);
        stall_en = 1'b1;
        repeat (150) begin
            rnd = lfsr(rnd);
            send_pkt(3 + int'(rnd[2:0]), int'(rnd[9:8]) % 3);
        end
        stall_en = 1'b0;
        repeat (200) @(posedge ref_clk_i);
        check(DATA_W'(expq.size()), '0);
        final_report();
    end
endmodule
